// File: verilog/tcsr_pkg.sv
// Package: offsets, fields, reset values and carriers of the test registers
package tcsr_pkg;

  // ----------------------------------------------------------------
  // Port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] TCSR_TEST_ENABLE_ADDR = 16'hA872;
  localparam logic [15:0] TCSR_TEST_STATUS_ADDR = 16'hDC72;

  // ----------------------------------------------------------------
  // Test enable fields
  // ----------------------------------------------------------------
  localparam int unsigned  TCSR_LVL_EN_BIT   = 0;
  localparam int unsigned  TCSR_FA_DIS_BIT   = 1;
  localparam int unsigned  TCSR_PLD_EN_BIT   = 2;
  localparam int unsigned  TCSR_EN_RW_MSB    = 9;
  localparam logic [9:0]   TCSR_EN_RST       = 10'h000;
  localparam logic [5:0]   TCSR_EN_RO_VAL    = 6'h00;

  // ----------------------------------------------------------------
  // Output buffer strength codes
  // ----------------------------------------------------------------
  localparam logic [1:0]   TCSR_STR_LOW      = 2'h0;
  localparam logic [1:0]   TCSR_STR_INVALID  = 2'h1;
  localparam logic [1:0]   TCSR_STR_MEDIUM   = 2'h2;
  localparam logic [1:0]   TCSR_STR_FULL     = 2'h3;
  localparam logic [15:0]  TCSR_UNMAPPED_VAL = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       cal_done;
    logic       medium_strength_flag;
    logic       slow_strength_flag;
    logic [6:0] delay_test_nodes;
    logic [4:0] buffer_test_nodes;
    logic       buffer_check_node;
  } tcsr_status_type;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } tcsr_io_req_type;

endpackage

// File: verilog/tcsr_regs.sv
// Test enable control and test status report registers
//
// Behaviour
// R1: With pulldown_enable set, pulldowns on address 23..0 and data 15..0 are on in power down.
// R2: With first_access_page_disable set, first-access page cycles are replaced by page-miss cycles.
// R3: With level_interrupt_enable clear, the edge/level select bit has no effect and edges are used.
// R4: With level_interrupt_enable set, the edge/level select bit picks edge or level sensing.
// R5: The test status report is a read-only 16-bit register at DC72H with no reset value.
// R6: Status bit 15 shows whether delay line calibration has completed.
// R7: Status bits 14 and 13 show the output buffer strength code, 01 being invalid.
// R8: Status bits 12-06, 05-01 and 00 show internal test nodes.
// R9: Writes to the test status report are ignored.
`timescale 1ns/1ps
`default_nettype none

module tcsr_regs
  import tcsr_pkg::*;
(
  input  wire logic            ref_clk_i,
  input  wire logic            srst_i,
  input  wire logic            io_rd_i,
  input  wire logic            io_wr_i,
  input  wire logic [15:0]     io_addr_i,
  input  wire logic [15:0]     io_wdata_i,
  output logic      [15:0]     io_rdata_o,
  output logic                 io_rdata_valid_o,
  input  wire logic            cpu_power_down_i,
  input  wire logic            full_power_down_i,
  input  wire logic            first_access_req_i,
  input  wire logic            edge_level_select_i,
  input  wire tcsr_status_type status_nodes_i,
  output logic      [23:0]     addr_pulldown_en_o,
  output logic      [15:0]     data_pulldown_en_o,
  output logic                 first_access_grant_o,
  output logic                 page_miss_force_o,
  output logic                 level_sense_mode_o,
  output logic                 strength_invalid_o
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  tcsr_io_req_type req;
  logic [9:0]      test_enable_ff;
  logic [9:0]      nxt_test_enable;
  tcsr_status_type status_ff;
  logic [15:0]     rdata_ff;
  logic [15:0]     nxt_rdata;
  logic            rvalid_ff;
  logic [23:0]     addr_pd_ff;
  logic [15:0]     data_pd_ff;
  logic            fa_grant_ff;
  logic            miss_force_ff;
  logic            lvl_mode_ff;
  logic            str_inv_ff;

  wire hit_enable  = (req.addr == TCSR_TEST_ENABLE_ADDR);
  wire hit_status  = (req.addr == TCSR_TEST_STATUS_ADDR);
  wire wr_enable   = req.wr && hit_enable;
  wire pld_en      = test_enable_ff[TCSR_PLD_EN_BIT];
  wire fa_dis      = test_enable_ff[TCSR_FA_DIS_BIT];
  wire lvl_en      = test_enable_ff[TCSR_LVL_EN_BIT];
  wire power_down  = cpu_power_down_i || full_power_down_i;
  wire pd_on       = pld_en && power_down;                                    // [R1]
  wire grant_next  = first_access_req_i && !fa_dis;                           // [R2]
  wire miss_next   = first_access_req_i && fa_dis;                            // [R2]
  wire lvl_next    = lvl_en && edge_level_select_i;                           // [R3] [R4]
  wire [1:0] str_code = {status_ff.medium_strength_flag, status_ff.slow_strength_flag};

  assign req.rd    = io_rd_i;
  assign req.wr    = io_wr_i;
  assign req.addr  = io_addr_i;
  assign req.wdata = io_wdata_i;

  assign nxt_test_enable = wr_enable ? req.wdata[TCSR_EN_RW_MSB:0] : test_enable_ff;
  assign nxt_rdata = hit_enable ? {TCSR_EN_RO_VAL, test_enable_ff} :
                     hit_status ? status_ff :                                 // [R5]
                     TCSR_UNMAPPED_VAL;

  // ----------------------------------------------------------------
  // Test enable control
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      test_enable_ff <= TCSR_EN_RST;
    end else begin
      test_enable_ff <= nxt_test_enable;
    end
  end

  // ----------------------------------------------------------------
  // Test status report, sampled every cycle, not reset
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    status_ff <= status_nodes_i;                                              // [R6] [R7] [R8] [R9]
  end

  // ----------------------------------------------------------------
  // Read return
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= req.rd;
      if (req.rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      addr_pd_ff    <= 24'h000000;
      data_pd_ff    <= 16'h0000;
      fa_grant_ff   <= 1'b0;
      miss_force_ff <= 1'b0;
      lvl_mode_ff   <= 1'b0;
      str_inv_ff    <= 1'b0;
    end else begin
      addr_pd_ff    <= {24{pd_on}};                                           // [R1]
      data_pd_ff    <= {16{pd_on}};                                           // [R1]
      fa_grant_ff   <= grant_next;
      miss_force_ff <= miss_next;
      lvl_mode_ff   <= lvl_next;
      str_inv_ff    <= (str_code == TCSR_STR_INVALID);                        // [R7]
    end
  end

  assign io_rdata_o           = rdata_ff;
  assign io_rdata_valid_o     = rvalid_ff;
  assign addr_pulldown_en_o   = addr_pd_ff;
  assign data_pulldown_en_o   = data_pd_ff;
  assign first_access_grant_o = fa_grant_ff;
  assign page_miss_force_o    = miss_force_ff;
  assign level_sense_mode_o   = lvl_mode_ff;
  assign strength_invalid_o   = str_inv_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_pld_written;
    io_wr_i && io_addr_i == TCSR_TEST_ENABLE_ADDR && io_wdata_i[TCSR_PLD_EN_BIT];
  endsequence

  sequence s_status_read;
    io_rd_i && io_addr_i == TCSR_TEST_STATUS_ADDR;
  endsequence

  sequence s_enable_written;
    io_wr_i && io_addr_i == TCSR_TEST_ENABLE_ADDR;
  endsequence

  sequence s_enable_read;
    io_rd_i && io_addr_i == TCSR_TEST_ENABLE_ADDR;
  endsequence

  sequence s_code_invalid;
    (!status_nodes_i.medium_strength_flag && status_nodes_i.slow_strength_flag) ##1 1'b1;
  endsequence

  sequence s_code_valid;
    !(!status_nodes_i.medium_strength_flag && status_nodes_i.slow_strength_flag) ##1 1'b1;
  endsequence

  AST_PD_ON: assert property (s_pld_written ##1 (!io_wr_i && power_down)        // [R1]
    |=> addr_pulldown_en_o == 24'hFFFFFF && data_pulldown_en_o == 16'hFFFF)
    else $error("pulldowns not enabled in power down");
  AST_PD_OFF: assert property (!pld_en || !power_down                           // [R1]
    |=> addr_pulldown_en_o == 24'h000000 && data_pulldown_en_o == 16'h0000)
    else $error("pulldowns enabled while not allowed");
  AST_FA_DIS: assert property (fa_dis && first_access_req_i                     // [R2]
    |=> page_miss_force_o && !first_access_grant_o)
    else $error("first-access cycle not replaced by page miss");
  AST_FA_OK: assert property (!fa_dis && first_access_req_i                     // [R2]
    |=> first_access_grant_o && !page_miss_force_o)
    else $error("first-access cycle wrongly blocked");
  AST_LVL_OFF: assert property (!lvl_en |=> !level_sense_mode_o)                // [R3]
    else $error("level mode active while level enable clear");
  AST_LVL_SEL: assert property (lvl_en && $stable(lvl_en)                       // [R4]
    |=> level_sense_mode_o == $past(edge_level_select_i))
    else $error("level select not followed");
  AST_STATUS_RD: assert property (s_status_read                                 // [R5]
    |=> io_rdata_valid_o && io_rdata_o == $past(status_ff))
    else $error("status read returned wrong data");
  AST_CAL_BIT: assert property (s_status_read                                   // [R6]
    |=> io_rdata_o[15] == $past(status_nodes_i.cal_done, 2))
    else $error("calibration bit wrong");
  AST_STR_INV: assert property (s_code_invalid |=> strength_invalid_o)          // [R7]
    else $error("invalid strength code not flagged");
  AST_STR_VALID: assert property (s_code_valid |=> !strength_invalid_o)         // [R7]
    else $error("valid strength code flagged as invalid");
  AST_NODES: assert property (s_status_read                                     // [R8]
    |=> io_rdata_o[12:0] == $past({status_nodes_i.delay_test_nodes,
        status_nodes_i.buffer_test_nodes, status_nodes_i.buffer_check_node}, 2))
    else $error("test node bits wrong");
  AST_STATUS_WR: assert property (io_wr_i && io_addr_i == TCSR_TEST_STATUS_ADDR // [R9]
    |=> test_enable_ff == $past(test_enable_ff) && status_ff == $past(status_nodes_i))
    else $error("status write disturbed a register");
  AST_EN_WRITE: assert property (s_enable_written                               // [R1] [R2] [R3]
    |=> test_enable_ff == $past(io_wdata_i[TCSR_EN_RW_MSB:0]))
    else $error("test enable write did not land");
  AST_EN_READ: assert property (s_enable_read
    |=> io_rdata_valid_o && io_rdata_o == {TCSR_EN_RO_VAL, $past(test_enable_ff)})
    else $error("test enable read returned wrong data");
  AST_UNMAPPED_RD: assert property (io_rd_i && io_addr_i != TCSR_TEST_ENABLE_ADDR
    && io_addr_i != TCSR_TEST_STATUS_ADDR |=> io_rdata_o == TCSR_UNMAPPED_VAL)
    else $error("unmapped read returned data");
  AST_RVALID_IDLE: assert property (!io_rd_i |=> !io_rdata_valid_o)
    else $error("read valid without a read");
  AST_FA_IDLE: assert property (!first_access_req_i                              // [R2]
    |=> !first_access_grant_o && !page_miss_force_o)
    else $error("page cycle control active without a request");

endmodule // tcsr_regs

`default_nettype wire

// File: test/tcsr_regs_tb.sv
// Self-checking testbench of the test enable control and test status report registers
`timescale 1ns/1ps
`default_nettype none

module test_control_status_regs_tb;
  import tcsr_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic            ref_clk_i;
  logic            srst_i;
  logic            io_rd_i;
  logic            io_wr_i;
  logic [15:0]     io_addr_i;
  logic [15:0]     io_wdata_i;
  logic [15:0]     io_rdata_o;
  logic            io_rdata_valid_o;
  logic            cpu_power_down_i;
  logic            full_power_down_i;
  logic            first_access_req_i;
  logic            edge_level_select_i;
  tcsr_status_type status_nodes_i;
  logic [23:0]     addr_pulldown_en_o;
  logic [15:0]     data_pulldown_en_o;
  logic            first_access_grant_o;
  logic            page_miss_force_o;
  logic            level_sense_mode_o;
  logic            strength_invalid_o;
  logic [15:0]     exp_q[$];
  int              errors;
  int              checks_done;
  int              seed;
  logic [15:0]     v;
  logic [3:0]      c;
  logic            pd;

  tcsr_regs tcsr_regs_i (
    .ref_clk_i            (ref_clk_i),
    .srst_i               (srst_i),
    .io_rd_i              (io_rd_i),
    .io_wr_i              (io_wr_i),
    .io_addr_i            (io_addr_i),
    .io_wdata_i           (io_wdata_i),
    .io_rdata_o           (io_rdata_o),
    .io_rdata_valid_o     (io_rdata_valid_o),
    .cpu_power_down_i     (cpu_power_down_i),
    .full_power_down_i    (full_power_down_i),
    .first_access_req_i   (first_access_req_i),
    .edge_level_select_i  (edge_level_select_i),
    .status_nodes_i       (status_nodes_i),
    .addr_pulldown_en_o   (addr_pulldown_en_o),
    .data_pulldown_en_o   (data_pulldown_en_o),
    .first_access_grant_o (first_access_grant_o),
    .page_miss_force_o    (page_miss_force_o),
    .level_sense_mode_o   (level_sense_mode_o),
    .strength_invalid_o   (strength_invalid_o)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic op(input logic rd, input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    io_rd_i    <= rd;
    io_wr_i    <= wr;
    io_addr_i  <= a;
    io_wdata_i <= d;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    op(1'b1, 1'b0, a, 16'h0000);
  endtask

  task automatic reset_checks();
    #1;
    check(24'({io_rdata_valid_o, first_access_grant_o, page_miss_force_o,
               level_sense_mode_o, strength_invalid_o}), 24'h000000);
    check(addr_pulldown_en_o, 24'h000000);
    check(24'(data_pulldown_en_o), 24'h000000);
    check(24'(io_rdata_o), 24'h000000);
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      io_rd_i <= 1'b0;
      io_wr_i <= 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // Clock, read monitor and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    if (io_rdata_valid_o === 1'b1) begin
      if (exp_q.size() == 0) check(24'h000001, 24'h000000);
      else check(24'(io_rdata_o), 24'(exp_q.pop_front()));
    end
  end

  initial begin
    #200000;
    errors++;
    results();
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    {io_rd_i, io_wr_i, io_addr_i, io_wdata_i, status_nodes_i} = '0;
    {cpu_power_down_i, full_power_down_i, first_access_req_i, edge_level_select_i} = 4'h0;
    errors = 0;
    checks_done = 0;
    seed = 18;
    srst_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    reset_checks();
    rd(TCSR_TEST_ENABLE_ADDR, 16'h0000);
    rd(16'h1234, TCSR_UNMAPPED_VAL);
    for (int i = 0; i < 24; i++) begin
      v = 16'($random(seed));
      c = 4'($random(seed));
      op(1'b0, 1'b1, TCSR_TEST_ENABLE_ADDR, v);
      {cpu_power_down_i, full_power_down_i, first_access_req_i, edge_level_select_i} <= c;
      op(1'b0, 1'b1, 16'h1234, ~v);
      rd(TCSR_TEST_ENABLE_ADDR, {TCSR_EN_RO_VAL, v[9:0]});
      idle(3);
      #1;
      pd = v[TCSR_PLD_EN_BIT] & (c[3] | c[2]);
      check(addr_pulldown_en_o, {24{pd}});
      check(24'(data_pulldown_en_o), 24'({16{pd}}));
      if (c[1]) check(24'({first_access_grant_o, page_miss_force_o}),
                      24'({~v[TCSR_FA_DIS_BIT], v[TCSR_FA_DIS_BIT]}));
      check(24'(level_sense_mode_o), 24'(v[TCSR_LVL_EN_BIT] & c[0]));
    end
    op(1'b0, 1'b1, TCSR_TEST_ENABLE_ADDR, 16'hFFFF);
    idle(1);
    srst_i <= 1'b1;
    idle(3);
    srst_i <= 1'b0;
    reset_checks();
    rd(TCSR_TEST_ENABLE_ADDR, {TCSR_EN_RO_VAL, TCSR_EN_RST});
    idle(3);
    for (int i = 0; i < 8; i++) begin
      v = 16'($random(seed));
      v[14:13] = 2'(i);
      @(posedge ref_clk_i);
      status_nodes_i <= v;
      idle(2);
      rd(TCSR_TEST_STATUS_ADDR, v);
      op(1'b0, 1'b1, TCSR_TEST_STATUS_ADDR, ~v);
      rd(TCSR_TEST_STATUS_ADDR, v);
      idle(2);
      #1;
      check(24'(strength_invalid_o), 24'(v[14:13] == TCSR_STR_INVALID));
    end
    idle(3);
    check(24'(exp_q.size()), 24'h000000);
    results();
  end
endmodule // test_control_status_regs_tb

`default_nettype wire
